/* design/ahp_map.svh */
// offsets, field positions, reset values and timing counts of the host port
`ifndef AHP_MAP_SVH
`define AHP_MAP_SVH

// host address decode
`define AHP_ADDR_FIFO_BIT  6
`define AHP_ADDR_TXQ       7'h40
`define AHP_ADDR_TXCFM     7'h41
`define AHP_ADDR_RXQ       7'h40
`define AHP_CFG_MODE       2'h0
`define AHP_CFG_MASK       2'h1
`define AHP_CFG_STAT       2'h2
`define AHP_CFG_LEVEL      2'h3

// queue depths in quadlets
`define AHP_TXQ_DEPTH      5'd24
`define AHP_RXQ_DEPTH      6'd39

// mode and status fields
`define AHP_MODE_TXEN      0
`define AHP_STAT_RXWORD    0
`define AHP_STAT_TXDRAIN   1
`define AHP_STAT_TXOVF     2

// reset values
`define AHP_MODE_RST       32'h0000_0000
`define AHP_MASK_RST       32'h0000_0000

// access timing
`define AHP_CLK_NS         25
`define AHP_TWAIT_WR_NS    100
`define AHP_TWAIT_WR_CYC   (`AHP_TWAIT_WR_NS / `AHP_CLK_NS)

`endif

/* design/ahp_pkg.sv */
// types shared by the host port modules
package ahp_pkg;
	typedef logic [31:0] ahp_quad_t;
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} ahp_state_e;
endpackage

/* design/ahp_stream_if.sv */
// quadlet stream with valid and ready between the port and its buffer
`timescale 1ns/100ps
interface ahp_stream_if;
	logic               valid;
	logic               ready;
	ahp_pkg::ahp_quad_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* design/ahp_skid_buf.sv */
// two-entry buffer on the transmit stream
`timescale 1ns/100ps
module ahp_skid_buf (
	// clock and reset
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	// streams
	ahp_stream_if.snk  in_s,
	ahp_stream_if.src  out_s
);
	import ahp_pkg::*;

	logic      out_valid_q;
	ahp_quad_t out_data_q;
	logic      skid_valid_q;
	ahp_quad_t skid_data_q;
	wire       take_in = in_s.valid & ~skid_valid_q;
	wire       move    = out_s.ready | ~out_valid_q;

	// output stage refills from skid first, else straight from input
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_valid_q  <= 1'b0;
			skid_valid_q <= 1'b0;
			out_data_q   <= 32'h0000_0000;
			skid_data_q  <= 32'h0000_0000;
		end else if (ce) begin
			if (move) begin
				out_valid_q  <= skid_valid_q | take_in;
				out_data_q   <= skid_valid_q ? skid_data_q : in_s.data;
				skid_valid_q <= 1'b0; // skid always empties on a move
			end else if (take_in) begin
				skid_valid_q <= 1'b1;
				skid_data_q  <= in_s.data;
			end
		end
	end

	assign in_s.ready  = ~skid_valid_q;
	assign out_s.valid = out_valid_q;
	assign out_s.data  = out_data_q;

	// a stalled word stays put until taken
	a_buf_hold_word: assert property (@(posedge clk) disable iff (!rst_n || !ce)
		out_valid_q && !out_s.ready |=> out_valid_q && $stable(out_data_q))
		else $error("buffered word changed while stalled");
endmodule // ahp_skid_buf

/* design/ahp_host_port.sv */
// parallel host cpu port with transmit and receive quadlet queues
`timescale 1ns/100ps
`include "ahp_map.svh"
module ahp_host_port (
	// clock, enable and reset
	input  wire logic               clk,
	input  wire logic               ce,
	input  wire logic               rst_n,
	// host pins
	input  wire logic               host_cs_n,
	input  wire logic               host_write_strobe_n,
	input  wire logic               host_read_strobe_n,
	input  wire logic [6:0]         host_addr,
	input  wire logic               bus_width_sel,
	input  wire logic [15:0]        host_data_in,
	output logic      [15:0]        host_data_out,
	output logic                    host_data_oe,
	output logic                    access_done_n,
	output logic                    access_done_oe,
	output logic                    host_irq_n,
	// transmit stream toward the link
	output ahp_pkg::ahp_quad_t      tx_word,
	output logic                    tx_valid,
	input  wire logic               tx_ready,
	// receive stream from the link
	input  wire ahp_pkg::ahp_quad_t rx_word,
	input  wire logic               rx_valid,
	output logic                    rx_ready
);
	import ahp_pkg::*;

	localparam int WR_WAIT = `AHP_TWAIT_WR_CYC;

	// lane insert and extract, 16-bit or 8-bit bus
	function automatic ahp_quad_t lane_put(ahp_quad_t q, logic [15:0] d, logic [1:0] p, logic w16);
		ahp_quad_t r;
		r = q;
		if (w16)
			r[{p[0], 4'h0} +: 16] = d;
		else
			r[{p, 3'h0} +: 8] = d[7:0];
		return r;
	endfunction

	function automatic logic [15:0] lane_get(ahp_quad_t q, logic [1:0] p, logic w16);
		logic [15:0] r;
		r = w16 ? q[{p[0], 4'h0} +: 16] : {8'h00, q[{p, 3'h0} +: 8]};
		return r;
	endfunction

	// pins pass two flops before use
	logic [26:0] pin_meta_q;
	logic [26:0] pin_q;
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_meta_q <= {4'hf, 23'h000000};
			pin_q      <= {4'hf, 23'h000000};
		end else if (ce) begin
			pin_meta_q <= {host_cs_n, host_write_strobe_n, host_read_strobe_n, bus_width_sel,
				host_addr, host_data_in};
			pin_q      <= pin_meta_q;
		end
	end

	wire        cs_s   = ~pin_q[26];
	wire        wr_s   = ~pin_q[25];
	wire        rd_s   = ~pin_q[24];
	wire        w16_s  = pin_q[23];
	wire [6:0]  addr_s = pin_q[22:16];
	wire [15:0] din_s  = pin_q[15:0];
	wire        req_s  = cs_s & (wr_s | rd_s);

	// state and storage
	ahp_state_e  state_q;
	logic        seq_wr_q;
	logic [6:0]  seq_addr_q;
	logic [1:0]  part_q;
	ahp_quad_t   asm_q;
	ahp_quad_t   rdq_q;
	ahp_quad_t   mode_q;
	ahp_quad_t   mask_q;
	logic [2:0]  stat_q;
	ahp_quad_t   txq_q [24];
	ahp_quad_t   rxq_q [39];
	logic [4:0]  tx_wp_q, tx_rp_q, tx_cnt_q, tx_com_q;
	logic [5:0]  rx_wp_q, rx_rp_q, rx_cnt_q;
	logic        done_n_q, done_oe_q, irq_n_q, rx_rdy_q, oe_q;
	logic [15:0] dout_q;

	// access decode
	wire        same_seq  = (addr_s == seq_addr_q) && (wr_s == seq_wr_q);
	wire [1:0]  part      = same_seq ? part_q : 2'h0;
	wire        last      = w16_s ? (part == 2'h1) : (part == 2'h3);
	wire        exec      = (state_q == ST_EXEC);
	wire        exec_wr   = exec & wr_s;
	wire        exec_rd   = exec & ~wr_s & rd_s;
	wire        is_fifo   = addr_s[`AHP_ADDR_FIFO_BIT];
	wire [1:0]  cfg_idx   = addr_s[1:0];
	wire        hit_txd   = (addr_s == `AHP_ADDR_TXQ);
	wire        hit_txc   = (addr_s == `AHP_ADDR_TXCFM);
	wire        hit_rx    = (addr_s == `AHP_ADDR_RXQ);
	ahp_quad_t  asm_d;
	assign      asm_d     = lane_put(asm_q, din_s, part, w16_s);
	wire        commit    = exec_wr & last;
	wire        tx_full   = (tx_cnt_q == `AHP_TXQ_DEPTH);
	wire        rx_empty  = (rx_cnt_q == 6'd0);
	wire        tx_push   = commit & (hit_txd | hit_txc) & ~tx_full;
	wire        tx_ovf    = commit & (hit_txd | hit_txc) & tx_full;
	wire        cfg_wr    = commit & ~is_fifo;
	wire        rx_pop    = exec_rd & last & hit_rx & ~rx_empty;

	// read source for the first part of a sequence
	ahp_quad_t  level_w;
	ahp_quad_t  cfg_rd;
	ahp_quad_t  rd_src;
	assign level_w = {11'h000, tx_com_q, 3'h0, tx_cnt_q, 2'h0, rx_cnt_q};
	assign cfg_rd  = (cfg_idx == `AHP_CFG_MODE) ? mode_q :
	                 (cfg_idx == `AHP_CFG_MASK) ? mask_q :
	                 (cfg_idx == `AHP_CFG_STAT) ? {29'h0, stat_q} : level_w;
	assign rd_src  = is_fifo ? ((hit_rx && !rx_empty) ? rxq_q[rx_rp_q] : 32'h0000_0000) : cfg_rd;
	ahp_quad_t  rd_quad;
	assign rd_quad = (part == 2'h0) ? rd_src : rdq_q;

	// transmit stream through the two-entry buffer
	ahp_stream_if buf_in ();
	ahp_stream_if buf_out ();
	wire        tx_pop = mode_q[`AHP_MODE_TXEN] & (tx_com_q != 5'd0) & buf_in.ready;
	assign buf_in.valid  = tx_pop;
	assign buf_in.data   = txq_q[tx_rp_q];
	assign buf_out.ready = tx_ready;
	ahp_skid_buf u_buf (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.in_s  (buf_in),
		.out_s (buf_out)
	);
	assign tx_word  = buf_out.data;
	assign tx_valid = buf_out.valid;

	// queue counts, confirm releases everything written so far
	wire        rx_push  = rx_valid & rx_rdy_q;
	wire [4:0]  tx_cnt_d = tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
	wire [5:0]  rx_cnt_d = rx_cnt_q + {5'h00, rx_push} - {5'h00, rx_pop};
	wire [4:0]  tx_com_d = (tx_push & hit_txc) ? tx_cnt_d : tx_com_q - {4'h0, tx_pop};
	wire        drained  = tx_pop & (tx_com_d == 5'd0); // a confirm in the same cycle keeps words released
	wire [2:0]  stat_set = {tx_ovf, drained, rx_push};
	wire [2:0]  stat_clr = (cfg_wr && cfg_idx == `AHP_CFG_STAT) ? asm_d[2:0] : 3'h0;
	wire [2:0]  stat_d   = (stat_q & ~stat_clr) | stat_set; // set wins over clear

	// access sequencer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q    <= ST_IDLE;
			part_q     <= 2'h0;
			seq_wr_q   <= 1'b0;
			seq_addr_q <= 7'h00;
			done_n_q   <= 1'b1;
		end else if (ce) begin
			case (state_q)
				ST_IDLE: if (req_s) state_q <= ST_EXEC;
				ST_EXEC: begin
					state_q    <= ST_DONE;
					done_n_q   <= 1'b0;
					seq_wr_q   <= wr_s;
					seq_addr_q <= addr_s;
					part_q     <= last ? 2'h0 : part + 2'h1;
				end
				ST_DONE: if (!req_s) begin
					state_q  <= ST_IDLE;
					done_n_q <= 1'b1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// assembly, read latch and data pins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			asm_q  <= 32'h0000_0000;
			rdq_q  <= 32'h0000_0000;
			dout_q <= 16'h0000;
			oe_q   <= 1'b0;
		end else if (ce) begin
			if (exec_wr) asm_q <= asm_d;
			if (exec_rd) rdq_q <= rd_quad;
			if (exec_rd) dout_q <= lane_get(rd_quad, part, w16_s);
			oe_q <= cs_s & rd_s & (state_q != ST_IDLE);
		end
	end

	// config registers and status
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_q    <= `AHP_MODE_RST;
			mask_q    <= `AHP_MASK_RST;
			stat_q    <= 3'h0;
			irq_n_q   <= 1'b1;
			done_oe_q <= 1'b0;
		end else if (ce) begin
			if (cfg_wr && cfg_idx == `AHP_CFG_MODE) mode_q <= asm_d;
			if (cfg_wr && cfg_idx == `AHP_CFG_MASK) mask_q <= asm_d;
			stat_q    <= stat_d;
			irq_n_q   <= ~|(stat_d & mask_q[2:0]);
			done_oe_q <= cs_s;
		end
	end

	// queue pointers and counts
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_wp_q  <= 5'd0;
			tx_rp_q  <= 5'd0;
			tx_cnt_q <= 5'd0;
			tx_com_q <= 5'd0;
			rx_wp_q  <= 6'd0;
			rx_rp_q  <= 6'd0;
			rx_cnt_q <= 6'd0;
			rx_rdy_q <= 1'b0;
		end else if (ce) begin
			if (tx_push) tx_wp_q <= (tx_wp_q == `AHP_TXQ_DEPTH - 5'd1) ? 5'd0 : tx_wp_q + 5'd1;
			if (tx_pop) tx_rp_q <= (tx_rp_q == `AHP_TXQ_DEPTH - 5'd1) ? 5'd0 : tx_rp_q + 5'd1;
			if (rx_push) rx_wp_q <= (rx_wp_q == `AHP_RXQ_DEPTH - 6'd1) ? 6'd0 : rx_wp_q + 6'd1;
			if (rx_pop) rx_rp_q <= (rx_rp_q == `AHP_RXQ_DEPTH - 6'd1) ? 6'd0 : rx_rp_q + 6'd1;
			tx_cnt_q <= tx_cnt_d;
			tx_com_q <= tx_com_d;
			rx_cnt_q <= rx_cnt_d;
			rx_rdy_q <= (rx_cnt_d < `AHP_RXQ_DEPTH);
		end
	end

	// queue storage
	always_ff @(posedge clk) begin
		if (ce && tx_push) txq_q[tx_wp_q] <= asm_d;
		if (ce && rx_push) rxq_q[rx_wp_q] <= rx_word;
	end

	assign host_data_out  = dout_q;
	assign host_data_oe   = oe_q;
	assign access_done_n  = done_n_q;
	assign access_done_oe = done_oe_q;
	assign host_irq_n     = irq_n_q;
	assign rx_ready       = rx_rdy_q;

	// checks, valid while ce is held high
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);

	sequence s_req_seen;
		state_q == ST_IDLE && req_s;
	endsequence
	sequence s_done_low;
		!access_done_n;
	endsequence

	a_done_in_time: assert property (s_req_seen |-> ##[1:WR_WAIT] s_done_low)
		else $error("completion late");
	a_done_held: assert property (state_q == ST_DONE && req_s |=> !access_done_n)
		else $error("completion dropped during access");
	a_irq_follows: assert property (|(stat_q & mask_q[2:0]) |-> ##[0:1] !host_irq_n)
		else $error("pending unmasked event without interrupt");
	a_tx_push_cnt: assert property (tx_push && !tx_pop |=> tx_cnt_q == $past(tx_cnt_q) + 5'd1)
		else $error("transmit word not queued");
	a_rx_push_cnt: assert property (rx_push && !rx_pop |=> rx_cnt_q == $past(rx_cnt_q) + 6'd1)
		else $error("receive word not queued");
	a_depth_limit: assert property (tx_cnt_q <= 5'd24 && rx_cnt_q <= 6'd39)
		else $error("queue depth exceeded");
	a_mask_write: assert property (cfg_wr && cfg_idx == `AHP_CFG_MASK |=> mask_q == $past(asm_d))
		else $error("mask write lost");
	a_partial_hold: assert property (exec_wr && !last |=> $stable(mask_q) && $stable(mode_q))
		else $error("partial access committed early");
	a_width_parts: assert property (exec && w16_s && part == 2'h1 |=> part_q == 2'h0 && state_q == ST_DONE)
		else $error("16-bit sequence not closed on second part");
	a_addr_decode: assert property (commit && addr_s == `AHP_ADDR_TXQ && !tx_full |=>
		tx_com_q == $past(tx_com_q) - {4'h0, $past(tx_pop)})
		else $error("plain queue write released words");
	a_confirm_release: assert property (commit && addr_s == `AHP_ADDR_TXCFM && !tx_full |=> tx_com_q == tx_cnt_q)
		else $error("confirm did not release queued words");
endmodule // ahp_host_port

/* verif/ahp_host_model.sv */
// host cpu model driving the parallel port pins
`timescale 1ns/100ps
module ahp_host_model (
	// clock
	input  wire logic        clk,
	// host pins
	output logic             cs_n,
	output logic             wr_n,
	output logic             rd_n,
	output logic [6:0]       addr,
	output logic             width,
	output logic [15:0]      dout,
	input  wire logic [15:0] din,
	input  wire logic        done_n,
	// hang flag
	output logic             hang
);
	// idle pins at time zero
	initial begin
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		addr = 7'h00;
		width = 1'b1;
		dout = 16'h5a5a;
		hang = 1'b0;
	end
	// one strobe cycle, held until completion is seen at an edge
	task automatic part(input logic w, input logic [6:0] a, input logic [15:0] d, output logic [15:0] q);
		int n;
		@(posedge clk);
		#2;
		addr = a;
		dout = w ? d : ~dout;
		cs_n = 1'b0;
		wr_n = !w;
		rd_n = w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (done_n !== 1'b0 && n < 60);
		q = din;
		if (n >= 60) hang = 1'b1;
		#2;
		cs_n = 1'b1;
		wr_n = 1'b1;
		rd_n = 1'b1;
		dout = ~dout; // released bus shows no stale value
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (done_n !== 1'b1 && n < 60);
		if (n >= 60) hang = 1'b1;
	endtask
	// whole quadlet as consecutive parts to one address
	task automatic quad(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
		logic [15:0] r;
		int          k;
		q = 32'h0000_0000;
		for (k = 0; k < (width ? 2 : 4); k++) begin
			part(w, a, width ? d[16*k +: 16] : {8'h00, d[8*k +: 8]}, r);
			if (width) q[16*k +: 16] = r;
			else q[8*k +: 8] = r[7:0];
		end
	endtask
endmodule // ahp_host_model

/* verif/tb_top.sv */
// self-checking bench for the host port
`timescale 1ns/100ps
`include "ahp_map.svh"
module tb_top;
	import ahp_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        cs_n, wr_n, rd_n, width, data_oe, done_n, done_oe, irq_n, hang;
	logic [6:0]  addr;
	logic [15:0] d_in, d_out;
	ahp_quad_t   tx_word, rx_word;
	logic        tx_valid, rx_ready;
	logic        tx_ready = 1'b0;
	logic        rx_valid = 1'b0;
	logic        ce = 1'b1;
	int          err_count = 0;
	int          total_checks = 0;
	initial rx_word = 32'h0f0f_0f0f;
	// 40 mhz clock
	always #12.5 clk = ~clk;
	ahp_host_model host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .width(width),
		.dout(d_in), .din(data_oe ? d_out : ~d_out), .done_n(done_n), .hang(hang));
	ahp_host_port uut (.clk(clk), .ce(ce), .rst_n(rst_n), .host_cs_n(cs_n), .host_write_strobe_n(wr_n),
		.host_read_strobe_n(rd_n), .host_addr(addr), .bus_width_sel(width), .host_data_in(d_in),
		.host_data_out(d_out), .host_data_oe(data_oe), .access_done_n(done_n), .access_done_oe(done_oe),
		.host_irq_n(irq_n), .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
	// compare tasks
	task automatic chk_q(string nm, ahp_quad_t e, ahp_quad_t g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_b(string nm, logic e, logic g);
		chk_q(nm, {31'h0, e}, {31'h0, g});
	endtask
	// config access helpers
	task automatic cfg(input logic w, input logic [1:0] i, input ahp_quad_t d, output ahp_quad_t q);
		host.quad(w, {5'h00, i}, d, q);
	endtask
	// one word into the receive stream
	task automatic push_rx(ahp_quad_t d);
		int n;
		@(posedge clk);
		#2;
		rx_word = d;
		rx_valid = 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rx_ready !== 1'b1 && n < 20);
		#2;
		rx_valid = 1'b0;
		rx_word = ~d;
		@(posedge clk);
	endtask
	// wait for an accepted transmit word and compare it
	task automatic pull_tx(ahp_quad_t e);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (!(tx_valid === 1'b1 && tx_ready) && n < 40);
		chk_q("tx_word", e, tx_word);
	endtask
	task automatic t_reset();
		ahp_quad_t q;
		chk_b("irq_n", 1'b1, irq_n);
		chk_b("tx_valid", 1'b0, tx_valid);
		chk_b("done_n", 1'b1, done_n);
		chk_b("done_oe", 1'b0, done_oe);
		chk_b("data_oe", 1'b0, data_oe);
		chk_b("rx_ready", 1'b1, rx_ready);
		cfg(1'b0, `AHP_CFG_MODE, 0, q);
		chk_q("mode", `AHP_MODE_RST, q);
		cfg(1'b0, `AHP_CFG_MASK, 0, q);
		chk_q("mask", `AHP_MASK_RST, q);
	endtask
	task automatic t_tx_fill();
		ahp_quad_t q;
		int        i;
		for (i = 0; i < 25; i++)
			host.quad(1'b1, i == 23 ? `AHP_ADDR_TXCFM : `AHP_ADDR_TXQ, 32'ha500_0000 + i, q);
		cfg(1'b0, `AHP_CFG_LEVEL, 0, q);
		chk_q("levels", 32'h0018_1800, q);
		cfg(1'b0, `AHP_CFG_STAT, 0, q);
		chk_q("status", 32'h4, q & 32'h7);
		cfg(1'b1, `AHP_CFG_MODE, 1, q);
		repeat (8) @(posedge clk);
		chk_q("stalled word", 32'ha500_0000, tx_word);
		#2;
		tx_ready = 1'b1;
		for (i = 0; i < 24; i++)
			pull_tx(32'ha500_0000 + i);
		#2;
		tx_ready = 1'b0;
		cfg(1'b0, `AHP_CFG_STAT, 0, q);
		chk_q("status", 32'h6, q & 32'h7);
		cfg(1'b1, `AHP_CFG_STAT, 7, q);
	endtask
	task automatic t_tx8();
		ahp_quad_t q;
		#2;
		host.width = 1'b0;
		host.quad(1'b1, `AHP_ADDR_TXQ, 32'h1122_3344, q);
		repeat (10) @(posedge clk);
		chk_b("tx_valid", 1'b0, tx_valid);
		host.quad(1'b1, `AHP_ADDR_TXCFM, 32'h5566_7788, q);
		#2;
		ce = 1'b0;
		tx_ready = 1'b1;
		repeat (4) @(posedge clk);
		chk_b("frozen tx_valid", 1'b1, tx_valid);
		chk_q("frozen tx_word", 32'h1122_3344, tx_word);
		#2;
		ce = 1'b1;
		pull_tx(32'h1122_3344);
		pull_tx(32'h5566_7788);
		#2;
		tx_ready = 1'b0;
		host.width = 1'b1;
	endtask
	task automatic t_rx_irq();
		ahp_quad_t q;
		push_rx(32'hcafe_0001);
		push_rx(32'hbeef_0002);
		repeat (4) @(posedge clk);
		chk_b("irq_n masked", 1'b1, irq_n);
		cfg(1'b1, `AHP_CFG_MASK, 1, q);
		repeat (4) @(posedge clk);
		chk_b("irq_n", 1'b0, irq_n);
		host.quad(1'b0, `AHP_ADDR_RXQ, 0, q);
		chk_q("rx16", 32'hcafe_0001, q);
		#2;
		host.width = 1'b0;
		host.quad(1'b0, `AHP_ADDR_RXQ, 0, q);
		chk_q("rx8", 32'hbeef_0002, q);
		#2;
		host.width = 1'b1;
		host.quad(1'b0, `AHP_ADDR_RXQ, 0, q);
		chk_q("rx empty", 32'h0, q);
		cfg(1'b1, `AHP_CFG_STAT, 1, q);
		repeat (4) @(posedge clk);
		chk_b("irq_n cleared", 1'b1, irq_n);
	endtask
	task automatic t_rx_full();
		ahp_quad_t q;
		int        i;
		for (i = 0; i < 39; i++)
			push_rx(32'h7700_0000 + i);
		repeat (2) @(posedge clk);
		chk_b("rx_ready", 1'b0, rx_ready);
		cfg(1'b0, `AHP_CFG_LEVEL, 0, q);
		chk_q("rx level", 32'd39, q & 32'h3f);
	endtask
	// verdict and end of run
	task automatic end_of_test();
		if (hang === 1'b1) err_count++;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (5) @(posedge clk);
		#2;
		rst_n = 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_tx_fill();
		t_tx8();
		t_rx_irq();
		t_rx_full();
		end_of_test();
	end
	// watchdog
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule // tb_top
